// ===== logic/tmr0_prescale.sv
// free-running prescaler giving the count clock enable
`timescale 1ns/1ns
`default_nettype none
module tmr0_prescale
	import tmr0_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// divide selection
	input  wire logic [10:0] div_mask,
	// count clock enable
	output var  logic        tick
);

	tmr0_psc_s q;
	tmr0_psc_s d;

	// never reset on start, so the first interval can run up to one count clock long
	always_comb begin
		d      = q;
		d.cnt  = 11'(q.cnt + 11'h001);
		d.tick = ((q.cnt & div_mask) == div_mask);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick = q.tick;

endmodule : tmr0_prescale
`default_nettype wire

// ===== logic/tmr0_sync.sv
// two-stage synchroniser with rising edge detect for the event pin
`timescale 1ns/1ns
`default_nettype none
module tmr0_sync
	import tmr0_pkg::*;
(
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	// pin side
	input  wire logic pin_in,
	// edge pulse
	output var  logic rise
);

	tmr0_sync_s q;
	tmr0_sync_s d;

	// s1 feeds s2 only; the edge is taken between s2 and s3
	always_comb begin
		d    = q;
		d.s1 = pin_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rise = q.s2 & ~q.s3;

endmodule : tmr0_sync
`default_nettype wire

// ===== logic/tmr0_top.sv
// 16-bit timer with two compare channels, output pins and apb registers
//
// How it works
// [RULE_01] software stops counting before reconfiguring
// [RULE_02] stop on match still raises request
// [RULE_03] software masks requests before stopping
// [RULE_04] counting starts within one count clock
// [RULE_05] compare write cycle blocks its match
// [RULE_06] software rewrites compare away from count
// [RULE_07] matches detected only on counter increment
// [RULE_08] disabled pin drives inverse active level
// [RULE_09] avoid counter reads at listed clock ratios
// [RULE_10] event count reads zero after one edge
// [RULE_11] software uses edge flag for first event
// [RULE_12] stop soon after match zero suppresses request
// [RULE_13] suppression never touches output pins
// [RULE_14] overflow or match one ends suppression; the code also ends it on the match zero whose request it drops
// [RULE_15] software waits window before stopping
// [RULE_16] software polls flags for short periods
// [RULE_17] one-shot mode gives one pulse per trigger
// [RULE_18] start bit sets active, match resets
// [RULE_19] stopping pulse output forces active level
// [RULE_20] match one sets period, zero the duty
`timescale 1ns/1ns
`default_nettype none
module tmr0_top
	import tmr0_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// pins
	input  wire logic        ext_event_in,
	output var  logic        timer_out0,
	output var  logic        timer_out1,
	// event requests
	output var  logic        match0_req,
	output var  logic        match1_req,
	output var  logic        overflow_req
);

	tmr0_state_s q;
	tmr0_state_s d;

	logic        psc_tick;
	logic        ev_edge;
	logic [10:0] mask;
	logic [11:0] div_len;
	logic [11:0] win_lim;
	logic        wr;
	logic        wr_ctrl;
	logic        wr_psc;
	logic        wr_setup;
	logic        wr_outc;
	logic        wr_cmp0;
	logic        wr_cmp1;
	logic        wr_osh;
	logic        wr_flag;
	logic        start;
	logic        stop;
	logic        clr_en;
	logic        tick;
	logic        at_max;
	logic        at_per;
	logic        ovf;
	logic        wrap;
	logic [15:0] cnt_nx;
	logic        hit0;
	logic        hit1;
	logic        req0_ok;
	logic        supp_set;
	logic        st0;
	logic        rt0;
	logic        st1;
	logic        rt1;
	logic [3:0]  flag_set;

	// next internal level of one channel; 1 means active
	function automatic logic out_next(
		input tmr0_mode_e mode,
		input logic       cur,
		input logic       hit,
		input logic       wr_p,
		input logic       st,
		input logic       rt,
		input logic       run,
		input logic       ppg_ch
	);
		logic r;
		r = cur;
		case (mode)
			TMR0_MODE_CMP: begin
				r = hit ? ~cur : cur;
			end
			TMR0_MODE_PWM: begin
				r = hit ? 1'b0 : (wr_p ? 1'b1 : cur);
			end
			TMR0_MODE_PPG: begin
				// [RULE_19] stopped means active
				// [RULE_20] duty on zero, period restart
				if (!ppg_ch) begin
					r = 1'b0;
				end else if (!run) begin
					r = 1'b1;
				end else begin
					r = hit ? 1'b0 : (wr_p ? 1'b1 : cur);
				end
			end
			TMR0_MODE_ONESHOT: begin
				// [RULE_17] single pulse per trigger
				// [RULE_18] start sets, match resets
				// reset wins if both bits are written together
				if (rt) begin
					r = 1'b0;
				end else if (st) begin
					r = 1'b1;
				end else if (hit) begin
					r = 1'b0;
				end
			end
			default: begin
				r = cur;
			end
		endcase
		return r;
	endfunction : out_next

	// pin level from enable, active level and internal state
	function automatic logic pin_level(
		input logic en,
		input logic alv,
		input logic act
	);
		// [RULE_08] disabled drives inverse
		return en ? (act ? alv : ~alv) : ~alv;
	endfunction : pin_level

	function automatic logic addr_ok(input logic [7:0] a);
		case (a)
			`TMR0_OFS_CTRL, `TMR0_OFS_PSC, `TMR0_OFS_SETUP,
			`TMR0_OFS_OUTC, `TMR0_OFS_CMP0, `TMR0_OFS_CMP1,
			`TMR0_OFS_COUNT, `TMR0_OFS_OSHOT, `TMR0_OFS_FLAGS: begin
				return 1'b1;
			end
			default: begin
				return 1'b0;
			end
		endcase
	endfunction : addr_ok

	tmr0_prescale u_psc (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.div_mask (mask),
		.tick     (psc_tick)
	);

	tmr0_sync u_sync (
		.mclk   (mclk),
		.rst_n  (rst_n),
		.pin_in (ext_event_in),
		.rise   (ev_edge)
	);

	assign mask    = tmr0_div_mask(q.psc_sel);
	assign div_len = 12'({1'b0, mask} + 12'h001);
	assign win_lim = 12'(div_len + (div_len >> 1));

	// apb decode; writes land only in the access phase
	assign wr       = psel & penable & pwrite;
	assign wr_ctrl  = wr & (paddr == `TMR0_OFS_CTRL);
	assign wr_psc   = wr & (paddr == `TMR0_OFS_PSC);
	assign wr_setup = wr & (paddr == `TMR0_OFS_SETUP);
	assign wr_outc  = wr & (paddr == `TMR0_OFS_OUTC);
	assign wr_cmp0  = wr & (paddr == `TMR0_OFS_CMP0);
	assign wr_cmp1  = wr & (paddr == `TMR0_OFS_CMP1);
	assign wr_osh   = wr & (paddr == `TMR0_OFS_OSHOT);
	assign wr_flag  = wr & (paddr == `TMR0_OFS_FLAGS);

	assign start = wr_ctrl & pwdata[`TMR0_CTRL_RUN] & ~q.run;
	assign stop  = wr_ctrl & ~pwdata[`TMR0_CTRL_RUN] & q.run;

	assign st0 = wr_osh & pwdata[`TMR0_OS_ST0];
	assign rt0 = wr_osh & pwdata[`TMR0_OS_RT0];
	assign st1 = wr_osh & pwdata[`TMR0_OS_ST1];
	assign rt1 = wr_osh & pwdata[`TMR0_OS_RT1];

	// [RULE_04] free prescaler, start latency
	// [RULE_10] first event edge only arms
	assign tick   = q.run & (q.ext_mode ? (ev_edge & q.armed) : psc_tick);
	assign clr_en = q.clr1 | (q.mode == TMR0_MODE_PPG);
	assign at_max = (q.count == `TMR0_COUNT_MAX);
	assign at_per = clr_en & (q.count == q.cmp1);
	assign ovf    = tick & at_max;
	assign wrap   = tick & (at_max | at_per);
	assign cnt_nx = wrap ? `TMR0_COUNT_RST : 16'(q.count + 16'h0001);

	// [RULE_07] match only on increment
	// [RULE_05] write cycle masks match
	assign hit0 = tick & (cnt_nx == q.cmp0) & ~wr_cmp0;
	assign hit1 = tick & (cnt_nx == q.cmp1) & ~wr_cmp1;

	// [RULE_12] drop first match zero request
	assign req0_ok  = hit0 & ~q.supp0;
	assign supp_set = stop & (q.win_open | hit0);

	// [RULE_11] edge flag on every edge
	assign flag_set = {ev_edge, ovf, hit1, req0_ok};

	always_comb begin
		d       = q;
		d.req0  = 1'b0;
		d.req1  = 1'b0;
		d.reqov = 1'b0;

		if (wr_ctrl) begin
			d.run      = pwdata[`TMR0_CTRL_RUN];
			d.ext_mode = pwdata[`TMR0_CTRL_EXT];
		end
		if (wr_psc) begin
			d.psc_sel = pwdata[`TMR0_PSC_MSB:0];
		end
		if (wr_setup) begin
			d.mode = tmr0_mode_e'(pwdata[`TMR0_MODE_MSB:0]);
			d.clr1 = pwdata[`TMR0_SETUP_CLR1];
		end
		if (wr_outc) begin
			d.en0  = pwdata[`TMR0_OUT_EN0];
			d.alv0 = pwdata[`TMR0_OUT_ALV0];
			d.en1  = pwdata[`TMR0_OUT_EN1];
			d.alv1 = pwdata[`TMR0_OUT_ALV1];
		end
		if (wr_cmp0) begin
			d.cmp0 = pwdata[`TMR0_CMP_MSB:0];
		end
		if (wr_cmp1) begin
			d.cmp1 = pwdata[`TMR0_CMP_MSB:0];
		end

		// [RULE_02] tick still completes on stop
		if (start) begin
			d.count = `TMR0_COUNT_RST;
			d.armed = 1'b0;
		end else if (tick) begin
			d.count = cnt_nx;
		end
		if (q.run & q.ext_mode & ev_edge) begin
			d.armed = 1'b1;
		end

		// window of 1.5 count clocks after each match zero
		if (hit0) begin
			d.win_open = 1'b1;
			d.win_cnt  = '0;
		end else if (q.win_open) begin
			d.win_cnt = 12'(q.win_cnt + 12'h001);
			if (q.win_cnt == 12'(win_lim - 12'h001)) begin
				d.win_open = 1'b0;
			end
		end

		// [RULE_14] overflow, match one or match zero clears
		if (hit0 | hit1 | ovf) begin
			d.supp0 = 1'b0;
		end
		if (supp_set) begin
			d.supp0 = 1'b1;
		end

		// [RULE_02] request raised despite stop
		d.req0  = req0_ok;
		d.req1  = hit1;
		d.reqov = ovf;

		// hardware set beats a software clear in the same cycle
		if (wr_flag) begin
			d.flags = q.flags & ~pwdata[`TMR0_FLAG_MSB:0];
		end
		d.flags = d.flags | flag_set;

		// [RULE_13] pins use raw matches
		d.out0 = out_next(q.mode, q.out0, hit0, wrap, st0, rt0, d.run, 1'b1);
		d.out1 = out_next(q.mode, q.out1, hit1, wrap, st1, rt1, d.run, 1'b0);
		d.pin0 = pin_level(d.en0, d.alv0, d.out0);
		d.pin1 = pin_level(d.en1, d.alv1, d.out1);

		// read data captured in setup, so it is steady in the access phase
		if (psel & ~penable & ~pwrite) begin
			case (paddr)
				`TMR0_OFS_CTRL: begin
					d.rdata = 32'({q.ext_mode, q.run});
				end
				`TMR0_OFS_PSC: begin
					d.rdata = 32'(q.psc_sel);
				end
				`TMR0_OFS_SETUP: begin
					d.rdata = 32'({q.clr1, q.mode});
				end
				`TMR0_OFS_OUTC: begin
					d.rdata = 32'({q.alv1, q.en1, q.alv0, q.en0});
				end
				`TMR0_OFS_CMP0: begin
					d.rdata = 32'(q.cmp0);
				end
				`TMR0_OFS_CMP1: begin
					d.rdata = 32'(q.cmp1);
				end
				`TMR0_OFS_COUNT: begin
					d.rdata = 32'(q.count);
				end
				`TMR0_OFS_FLAGS: begin
					d.rdata = 32'(q.flags);
				end
				default: begin
					d.rdata = `TMR0_DATA_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q      <= '0;
			q.pin0 <= `TMR0_PIN_RST;
			q.pin1 <= `TMR0_PIN_RST;
		end else begin
			q <= d;
		end
	end

	assign prdata       = q.rdata;
	assign pready       = 1'b1;
	assign pslverr      = psel & penable & ~addr_ok(paddr);
	assign timer_out0   = q.pin0;
	assign timer_out1   = q.pin1;
	assign match0_req   = q.req0;
	assign match1_req   = q.req1;
	assign overflow_req = q.reqov;

endmodule : tmr0_top
`default_nettype wire

// ===== pkg/tmr0_defines.svh
// register offsets, field positions and reset values of the timer block
`ifndef TMR0_DEFINES_SVH
`define TMR0_DEFINES_SVH

`define TMR0_OFS_CTRL   8'h00
`define TMR0_OFS_PSC    8'h04
`define TMR0_OFS_SETUP  8'h08
`define TMR0_OFS_OUTC   8'h0C
`define TMR0_OFS_CMP0   8'h10
`define TMR0_OFS_CMP1   8'h14
`define TMR0_OFS_COUNT  8'h18
`define TMR0_OFS_OSHOT  8'h1C
`define TMR0_OFS_FLAGS  8'h20

`define TMR0_CTRL_RUN   0
`define TMR0_CTRL_EXT   1
`define TMR0_PSC_MSB    3
`define TMR0_MODE_MSB   1
`define TMR0_SETUP_CLR1 2
`define TMR0_OUT_EN0    0
`define TMR0_OUT_ALV0   1
`define TMR0_OUT_EN1    2
`define TMR0_OUT_ALV1   3
`define TMR0_OS_ST0     0
`define TMR0_OS_RT0     1
`define TMR0_OS_ST1     2
`define TMR0_OS_RT1     3
`define TMR0_FLAG_MSB   3
`define TMR0_CMP_MSB    15

`define TMR0_COUNT_MAX  16'hFFFF
`define TMR0_COUNT_RST  16'h0000
`define TMR0_PIN_RST    1'b1
`define TMR0_DIV_MIN    12'h008
`define TMR0_PSC_LAST   4'h8
`define TMR0_DATA_ZERO  32'h0000_0000

`endif

// ===== pkg/tmr0_pkg.sv
// types and shared decoding of the timer block
`default_nettype none
package tmr0_pkg;
`include "tmr0_defines.svh"

	typedef enum logic [1:0] {
		TMR0_MODE_CMP,
		TMR0_MODE_PWM,
		TMR0_MODE_PPG,
		TMR0_MODE_ONESHOT
	} tmr0_mode_e;

	typedef struct packed {
		logic [10:0] cnt;
		logic        tick;
	} tmr0_psc_s;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} tmr0_sync_s;

	typedef struct packed {
		logic        run;
		logic        ext_mode;
		logic        armed;
		logic [3:0]  psc_sel;
		tmr0_mode_e  mode;
		logic        clr1;
		logic        en0;
		logic        alv0;
		logic        en1;
		logic        alv1;
		logic [15:0] cmp0;
		logic [15:0] cmp1;
		logic [15:0] count;
		logic        out0;
		logic        out1;
		logic        pin0;
		logic        pin1;
		logic [3:0]  flags;
		logic        supp0;
		logic        win_open;
		logic [11:0] win_cnt;
		logic [31:0] rdata;
		logic        req0;
		logic        req1;
		logic        reqov;
	} tmr0_state_s;

	// divide factor 8 << sel minus one; selections past the last clamp
	function automatic logic [10:0] tmr0_div_mask(input logic [3:0] sel);
		logic [3:0]  s;
		logic [11:0] dv;
		s  = (sel > `TMR0_PSC_LAST) ? `TMR0_PSC_LAST : sel;
		dv = `TMR0_DIV_MIN << s;
		return 11'(dv - 12'h001);
	endfunction : tmr0_div_mask

endpackage : tmr0_pkg
`default_nettype wire

// ===== test/tmr0_checker.sv
// port checker for the timer block, bound to its top
`timescale 1ns/1ns
`default_nettype none
module tmr0_checker
	import tmr0_pkg::*;
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst_n,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pins and requests
	input wire logic        ext_event_in,
	input wire logic        timer_out0,
	input wire logic        timer_out1,
	input wire logic        match0_req,
	input wire logic        match1_req,
	input wire logic        overflow_req
);
`include "tmr0_defines.svh"
	logic       acc;
	logic       unmap;
	logic [3:0] outc_q;
	assign acc = psel & penable;
	assign unmap = paddr > `TMR0_OFS_FLAGS || paddr[1:0] != 2'h0;
	// shadow of output control, seen only through writes
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			outc_q <= 4'h0;
		else if (acc && pwrite && paddr == `TMR0_OFS_OUTC)
			outc_q <= pwdata[3:0];
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	pready_on_a: assert property (pready) else $error("pready low");
	unmap_err_a: assert property (acc && unmap |-> pslverr)
		else $error("no error on unmapped access");
	unmap_rd_a: assert property (acc && !pwrite && unmap |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	oshot_rd_a: assert property (
		acc && !pwrite && paddr == `TMR0_OFS_OSHOT |-> prdata == 32'h0)
		else $error("strobe register read not zero");
	cmp0_wr_a: assert property (
		acc && pwrite && paddr == `TMR0_OFS_CMP0 |=> !match0_req)
		else $error("match zero during its write");
	cmp1_wr_a: assert property (
		acc && pwrite && paddr == `TMR0_OFS_CMP1 |=> !match1_req)
		else $error("match one during its write");
	// registered pin changes on the same edge as the shadow
	dis_pin0_a: assert property (
		!outc_q[0] && $stable(outc_q) |-> timer_out0 == !outc_q[1])
		else $error("disabled pin zero wrong level");
	dis_pin1_a: assert property (
		!outc_q[2] && $stable(outc_q) |-> timer_out1 == !outc_q[3])
		else $error("disabled pin one wrong level");
	cover property (match0_req);
	cover property (match1_req);
	cover property (acc && unmap);
endmodule : tmr0_checker
bind tmr0_top tmr0_checker u_chk (.mclk, .rst_n, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .ext_event_in, .timer_out0,
	.timer_out1, .match0_req, .match1_req, .overflow_req);
`default_nettype wire

// ===== test/tmr0_top_tb.sv
// self-checking bench for the timer block
`timescale 1ns/1ns
`default_nettype none
module tmr0_top_tb
	import tmr0_pkg::*;
;
`include "tmr0_defines.svh"
	logic        mclk, rst_n, psel, penable, pwrite, ext_event_in;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, timer_out0, timer_out1;
	logic        match0_req, match1_req, overflow_req;
	int          err_count, comparisons, n, t;
	tmr0_top dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .ext_event_in, .timer_out0,
		.timer_out1, .match0_req, .match1_req, .overflow_req);
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("Error at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : check
	task automatic pin(input logic s, input logic e);
		check({31'h0, s}, {31'h0, e});
	endtask : pin
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(rd, e);
	endtask : rdc
	task automatic cy(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : cy
	// waits for match zero, match one, pin high or pin low; n counts edges
	task automatic wt(input int w);
		n = 0;
		do begin
			cy(1);
			n++;
		end while (n < 3000 && !(w == 0 ? match0_req : w == 1 ? match1_req :
			w == 2 ? timer_out0 : !timer_out0));
		check(32'(n < 3000), 32'h1);
	endtask : wt
	task automatic pulse;
		@(posedge mclk) ext_event_in <= 1'b1;
		cy(4);
		@(posedge mclk) ext_event_in <= 1'b0;
		cy(4);
	endtask : pulse
	task automatic done_t;
		t++;
		$display("test %0d finished", t);
	endtask : done_t
	task automatic give_verdict;
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		#200000;
		err_count++;
		give_verdict;
	end
	initial begin
		{rst_n, psel, penable, pwrite, ext_event_in} = 5'h0;
		{paddr, pwdata, err_count, comparisons, t} = '0;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		cy(1);
		pin(timer_out0, 1'b1);
		rdc(`TMR0_OFS_OSHOT, 32'h0);
		rdc(8'h40, 32'h0);
		wr(`TMR0_OFS_OUTC, 32'hA);
		cy(2);
		pin(timer_out0, 1'b0);
		pin(timer_out1, 1'b0);
		done_t;
		wr(`TMR0_OFS_CMP0, 32'h5);
		wr(`TMR0_OFS_OUTC, 32'h3);
		wr(`TMR0_OFS_CTRL, 32'h1);
		wt(0);
		check(32'(n >= 33 && n <= 40), 32'h1);
		pin(timer_out0, 1'b1);
		rdc(`TMR0_OFS_FLAGS, 32'h1);
		wr(`TMR0_OFS_CMP0, 32'h5);
		// equal to the count now, so no match may follow
		cy(1);
		pin(match0_req, 1'b0);
		// stop well clear of the match window
		cy(12);
		wr(`TMR0_OFS_CTRL, 32'h0);
		done_t;
		// stopped before any reconfiguration
		wr(`TMR0_OFS_SETUP, 32'h2);
		wr(`TMR0_OFS_CMP1, 32'h9);
		wr(`TMR0_OFS_CMP0, 32'h3);
		wr(`TMR0_OFS_CTRL, 32'h1);
		wt(1);
		wt(1);
		check(32'(n), 32'd80);
		wt(0);
		pin(timer_out0, 1'b0);
		wt(2);
		check(32'(n), 32'd56);
		pin(overflow_req, 1'b0);
		wt(0);
		wr(`TMR0_OFS_CTRL, 32'h0);
		cy(2);
		pin(timer_out0, 1'b1);
		wr(`TMR0_OFS_CTRL, 32'h1);
		wt(3);
		pin(match0_req, 1'b0);
		pin(timer_out0, 1'b0);
		wt(0);
		check(32'(n), 32'd80);
		cy(16);
		wr(`TMR0_OFS_CTRL, 32'h0);
		done_t;
		wr(`TMR0_OFS_SETUP, 32'h7);
		wr(`TMR0_OFS_CMP1, 32'h7);
		wr(`TMR0_OFS_CMP0, 32'h4);
		wr(`TMR0_OFS_CTRL, 32'h1);
		wr(`TMR0_OFS_OSHOT, 32'h2);
		cy(2);
		pin(timer_out0, 1'b0);
		wt(0);
		wr(`TMR0_OFS_OSHOT, 32'h1);
		cy(2);
		pin(timer_out0, 1'b1);
		wt(0);
		pin(timer_out0, 1'b0);
		wt(0);
		pin(timer_out0, 1'b0);
		wr(`TMR0_OFS_OSHOT, 32'h1);
		wr(`TMR0_OFS_OSHOT, 32'h2);
		cy(2);
		pin(timer_out0, 1'b0);
		done_t;
		// stop clear of the match window
		cy(12);
		wr(`TMR0_OFS_CTRL, 32'h2);
		wr(`TMR0_OFS_FLAGS, 32'hF);
		wr(`TMR0_OFS_CTRL, 32'h3);
		pulse;
		rdc(`TMR0_OFS_COUNT, 32'h0);
		rdc(`TMR0_OFS_FLAGS, 32'h8);
		pulse;
		rdc(`TMR0_OFS_COUNT, 32'h1);
		done_t;
		give_verdict;
	end
endmodule : tmr0_top_tb
`default_nettype wire
